// ==== pwr_seq_pkg.sv ====
// Purpose: Shared constants for the relay driver power-mode and reset sequencer.
// Assumes: Core clock of 200 MHz.
// Notes: Times are given in their own unit; cycle counts derive from them.
package pwr_seq_pkg;
   // ----------------------------------------
   // Clock and timing
   // ----------------------------------------
   localparam int CLK_MHZ = 200;
   localparam int WAKEUP_SETTLE_TIME_US = 200;
   localparam int WAKEUP_SETTLE_CYCLES = WAKEUP_SETTLE_TIME_US * CLK_MHZ;
   localparam int UV_RESET_DELAY_US = 1;
   localparam int UV_RESET_DELAY_CYCLES = UV_RESET_DELAY_US * CLK_MHZ;
   localparam int SETTLE_W = 16;
   // ----------------------------------------
   // Widths and reset values
   // ----------------------------------------
   localparam int CHANNELS = 8;
   localparam int BANK_W = 32;
   localparam int DIAG_W = 16;
   localparam logic [31:0] BANK_DEFAULT = 32'h00000000;
   localparam logic [15:0] DIAG_DEFAULT = 16'h0000;
   localparam logic [7:0] CHAN_OFF = 8'h00;
   typedef enum logic [1:0] {MODE_SLEEP, MODE_SETTLE, MODE_ON} mode_t;
endpackage

// ==== uv_sync.sv ====
// Purpose: Two-stage synchroniser for one supply monitor level.
// Assumes: Input is asynchronous to clk.
// Notes: The first stage is read only by the second.
`timescale 1ns/10ps
module uv_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Level in and out
   input wire logic level_in,
   output logic level_out
);
   logic meta;

   // Resets to the unsafe value so the supply counts as low until seen good.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= 1'b1;
         level_out <= 1'b1;
      end else begin
         meta <= level_in;
         level_out <= meta;
      end
   end
endmodule

// ==== relay_driver_power_mode_reset.sv ====
// Purpose: Power-mode and reset sequencer of an eight-channel SPI relay driver.
// Assumes: Command bits are single-cycle pulses from the frame decoder.
// Notes: Undervoltage inputs are synchronised here; all outputs are registered.
`timescale 1ns/10ps
module relay_driver_power_mode_reset (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Supply monitors, high while the supply is below its threshold
   input wire logic logic_uv,
   input wire logic battery_uv,
   // Command bits from a decoded frame
   input wire logic frame_valid,
   input wire logic wake_command_bit,
   input wire logic standby_command_bit,
   input wire logic reset_command_bit,
   input wire logic frame_fault_clear,
   // Register bank write from a decoded frame
   input wire logic bank_write,
   input wire logic [31:0] bank_wdata,
   input wire logic diag_write,
   input wire logic [15:0] diag_wdata,
   input wire logic [7:0] channel_request,
   // Shift-register path
   input wire logic shift_in,
   output logic shift_out,
   output logic spi_active,
   // Status and state
   output logic awake_status,
   output logic settling,
   output logic frame_fault_flag,
   output logic uv_reset,
   output logic frame_accept,
   output logic diag_frame_fault,
   // Register banks and channels
   output logic [31:0] bank_data,
   output logic [15:0] diag_data,
   output logic [7:0] channel_on,
   output logic switches_enable
);
   // ----------------------------------------
   // Timing overview
   // ----------------------------------------
   // Internal reset lifts two edges after rst_b rises. The monitor synchronisers then
   // need two more edges and the reset flop one, so the block leaves undervoltage reset
   // about five edges after rst_b if both supplies are good.
   // A wake frame starts a settle interval of WAKEUP_SETTLE_CYCLES edges. Every frame
   // offered meanwhile is dropped, reset commands included; an undervoltage reset still
   // acts at once. This keeps one clean count with no queued command behind it.
   // Mode status flops load from the next-mode term so they move together with the
   // mode register and never show a stale state for a cycle.

   // ----------------------------------------
   // Reset release and monitor synchronisers
   // ----------------------------------------
   logic rst_meta;
   logic rst_n;
   logic logic_uv_s;
   logic battery_uv_s;
   localparam int SETTLE_W_L = pwr_seq_pkg::SETTLE_W;
   // The load is one less than the interval because a count of zero is the last cycle.
   localparam logic [15:0] SETTLE_LOAD = 16'(pwr_seq_pkg::WAKEUP_SETTLE_CYCLES - 1);
   logic any_reset;
   logic [SETTLE_W_L-1:0] settle_cnt;
   pwr_seq_pkg::mode_t mode;
   pwr_seq_pkg::mode_t next_mode;
   logic cmd_ok;
   // Derived control terms, named so each clear condition is written once.
   logic enter_settle;
   logic on_next;
   logic sleep_next;
   logic bank_clear;
   logic diag_clear;
   logic chan_force_off;
   logic switch_ok;

   // Reset is asserted at once but released through two flops.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // Two flops plus one output flop give 3 cycles, far inside the 200-cycle limit.
   // Both monitors reset to the low-supply value, so a supply only counts as good
   // once it has been seen good through both stages.
   uv_sync u_sync_logic (
      .clk(clk),
      .rst_n(rst_n),
      .level_in(logic_uv),
      .level_out(logic_uv_s)
   );
   uv_sync u_sync_batt (
      .clk(clk),
      .rst_n(rst_n),
      .level_in(battery_uv),
      .level_out(battery_uv_s)
   );

   // Undervoltage reset is held while either supply is low.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         uv_reset <= 1'b1;
      end else begin
         uv_reset <= logic_uv_s | battery_uv_s;
      end
   end

   // The undervoltage and command reset sources fold into one internal term; rst_b acts directly.
   assign any_reset = uv_reset | (cmd_ok & reset_command_bit);
   // Frames are dropped while settling and while the logic supply is absent.
   assign cmd_ok = frame_valid & (mode != pwr_seq_pkg::MODE_SETTLE) & ~logic_uv_s;

   // ----------------------------------------
   // Derived control terms
   // ----------------------------------------
   // The settle counter loads only on the edge that leaves sleep for settling.
   assign enter_settle = (mode != pwr_seq_pkg::MODE_SETTLE)
      & (next_mode == pwr_seq_pkg::MODE_SETTLE);
   // Outputs and clears look one edge ahead so they move with the mode register.
   assign on_next = (next_mode == pwr_seq_pkg::MODE_ON);
   assign sleep_next = (next_mode == pwr_seq_pkg::MODE_SLEEP);
   // Banks are wiped by any reset, by a missing battery and throughout sleep.
   assign bank_clear = any_reset | battery_uv_s | sleep_next;
   // Diagnosis registers survive a standby but not a reset or a missing battery.
   assign diag_clear = any_reset | battery_uv_s;
   // Channels follow their requests only in operation mode with the battery up.
   assign chan_force_off = any_reset | battery_uv_s | ~on_next;
   // Switch enable is the inverse of that condition, registered on its own flop.
   assign switch_ok = ~battery_uv_s & ~any_reset & on_next;

   // ----------------------------------------
   // Power mode
   // ----------------------------------------
   // Standby is tested before wake so a frame carrying both stays asleep.
   always_comb begin
      next_mode = mode;
      case (mode)
         pwr_seq_pkg::MODE_SLEEP: begin
            if (cmd_ok && !standby_command_bit && wake_command_bit) begin
               next_mode = pwr_seq_pkg::MODE_SETTLE;
            end
         end
         pwr_seq_pkg::MODE_SETTLE: begin
            if (settle_cnt == '0) begin
               next_mode = pwr_seq_pkg::MODE_ON;
            end
         end
         pwr_seq_pkg::MODE_ON: begin
            if (cmd_ok && standby_command_bit) begin
               next_mode = pwr_seq_pkg::MODE_SLEEP;
            end
         end
         default: begin
            next_mode = pwr_seq_pkg::MODE_SLEEP;
         end
      endcase
      if (any_reset) begin
         next_mode = pwr_seq_pkg::MODE_SLEEP;
      end
   end

   // Mode register starts in sleep after power-up.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode <= pwr_seq_pkg::MODE_SLEEP;
      end else begin
         mode <= next_mode;
      end
   end

   // ----------------------------------------
   // Settle interval
   // ----------------------------------------
   // Settle counter loads on the wake transition and counts down to zero.
   // A reset during settling leaves the count running, but the mode is already back in
   // sleep, so the stale count is harmless and the next wake overwrites it.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         settle_cnt <= '0;
      end else if (enter_settle) begin
         settle_cnt <= SETTLE_LOAD;
      end else if (settle_cnt != '0) begin
         settle_cnt <= settle_cnt - 16'h0001;
      end
   end

   // ----------------------------------------
   // Status outputs
   // ----------------------------------------
   // Mode status outputs.
   // Frame accept is a one-cycle echo of the taken edge, so a host can see refusals.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         awake_status <= 1'b0;
         settling <= 1'b0;
         frame_accept <= 1'b0;
      end else begin
         awake_status <= on_next;
         settling <= (next_mode == pwr_seq_pkg::MODE_SETTLE);
         frame_accept <= cmd_ok;
      end
   end

   // ----------------------------------------
   // Frame fault flag
   // ----------------------------------------
   // A reset in the same cycle as a clear wins, so the event is never lost.
   // The flag is sticky: only an accepted clear frame lowers it, so a host that polls
   // late still learns that a reset happened in between.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         frame_fault_flag <= 1'b1;
      end else if (any_reset) begin
         frame_fault_flag <= 1'b1;
      end else if (cmd_ok && frame_fault_clear) begin
         frame_fault_flag <= 1'b0;
      end
   end

   // ----------------------------------------
   // Shift path and diagnostic frame
   // ----------------------------------------
   // Reads during undervoltage flag the diagnostic frame; logic loss stops SPI.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         diag_frame_fault <= 1'b1;
         spi_active <= 1'b0;
         shift_out <= 1'b0;
      end else begin
         diag_frame_fault <= uv_reset | frame_fault_flag | any_reset;
         spi_active <= ~logic_uv_s;
         shift_out <= logic_uv_s ? 1'b0 : shift_in;
      end
   end

   // ----------------------------------------
   // Register banks and channels
   // ----------------------------------------
   // Banks clear on reset, on sleep and without battery; writes need operation mode.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bank_data <= pwr_seq_pkg::BANK_DEFAULT;
      end else if (bank_clear) begin
         bank_data <= pwr_seq_pkg::BANK_DEFAULT;
      end else if (cmd_ok && bank_write && mode == pwr_seq_pkg::MODE_ON) begin
         bank_data <= bank_wdata;
      end
   end

   // Diagnosis registers clear with any reset; they only run with battery present.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         diag_data <= pwr_seq_pkg::DIAG_DEFAULT;
      end else if (diag_clear) begin
         diag_data <= pwr_seq_pkg::DIAG_DEFAULT;
      end else if (diag_write && mode == pwr_seq_pkg::MODE_ON) begin
         diag_data <= diag_wdata;
      end
   end

   // ----------------------------------------
   // Channels and switch enable
   // ----------------------------------------
   // Each channel is gated per bit; battery loss and reset force every one off.
   genvar ch;
   generate
      for (ch = 0; ch < pwr_seq_pkg::CHANNELS; ch++) begin : g_chan
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               channel_on[ch] <= pwr_seq_pkg::CHAN_OFF[ch];
            end else if (chan_force_off) begin
               channel_on[ch] <= pwr_seq_pkg::CHAN_OFF[ch];
            end else begin
               channel_on[ch] <= channel_request[ch];
            end
         end
      end
   endgenerate

   // Switch enable tracks the battery and operation mode.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         switches_enable <= 1'b0;
      end else begin
         switches_enable <= switch_ok;
      end
   end
endmodule

// ==== pwr_seq_monitor.sv ====
// Purpose: Checker for the power-mode and reset sequencer ports.
// Assumes: One clock domain; rst_b is active low.
// Notes: Bound to every instance of the sequencer below.
`timescale 1ns/10ps
module pwr_seq_monitor (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Inputs watched
   input wire logic logic_uv,
   input wire logic battery_uv,
   input wire logic frame_valid,
   input wire logic wake_command_bit,
   input wire logic standby_command_bit,
   input wire logic reset_command_bit,
   input wire logic shift_in,
   // Outputs watched
   input wire logic shift_out,
   input wire logic spi_active,
   input wire logic awake_status,
   input wire logic settling,
   input wire logic frame_fault_flag,
   input wire logic uv_reset,
   input wire logic frame_accept,
   input wire logic [31:0] bank_data,
   input wire logic [7:0] channel_on
);
   localparam int UV_MAX = pwr_seq_pkg::UV_RESET_DELAY_CYCLES;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // --------------------------------
   // Properties
   // --------------------------------
   // A lone wake goes through the settle interval, never straight to operation.
   property p_wake;
      frame_accept && $past(wake_command_bit && !standby_command_bit && !reset_command_bit
         && !awake_status) |-> settling && !awake_status;
   endproperty
   a_wake: assert property (p_wake) else $error("wake did not start settling");
   property p_stb;
      frame_accept && $past(standby_command_bit) |-> !awake_status && !settling;
   endproperty
   a_stb: assert property (p_stb) else $error("standby left device awake");
   property p_rst;
      frame_accept && $past(reset_command_bit) |-> frame_fault_flag && !awake_status;
   endproperty
   a_rst: assert property (p_rst) else $error("reset command not applied");
   // Frames met while settling must be dropped.
   property p_refuse;
      settling && frame_valid |=> !frame_accept;
   endproperty
   a_refuse: assert property (p_refuse) else $error("frame taken while settling");
   property p_asleep;
      !awake_status |-> bank_data == 32'h00000000 && channel_on == 8'h00;
   endproperty
   a_asleep: assert property (p_asleep) else $error("banks set while asleep");
   property p_bat;
      battery_uv |-> ##[1:UV_MAX] uv_reset;
   endproperty
   a_bat: assert property (p_bat) else $error("battery undervoltage too slow");
   property p_logic;
      logic_uv |-> ##[1:UV_MAX] uv_reset;
   endproperty
   a_logic: assert property (p_logic) else $error("logic undervoltage too slow");
   property p_release;
      $fell(uv_reset) |-> !$past(battery_uv) && !$past(logic_uv);
   endproperty
   a_release: assert property (p_release) else $error("early reset release");
   property p_shift;
      spi_active && $past(spi_active) |-> shift_out == $past(shift_in);
   endproperty
   a_shift: assert property (p_shift) else $error("pass-through broken");
endmodule
bind relay_driver_power_mode_reset pwr_seq_monitor mon (.clk, .rst_b, .logic_uv, .battery_uv,
   .frame_valid, .wake_command_bit, .standby_command_bit, .reset_command_bit, .shift_in,
   .shift_out, .spi_active, .awake_status, .settling, .frame_fault_flag, .uv_reset,
   .frame_accept, .bank_data, .channel_on);

// ==== host_model.sv ====
// Purpose: Host side that sends decoded command frames.
// Assumes: One frame per call of send.
// Notes: Idle bits are inverted so a stale command never looks valid.
`timescale 1ns/10ps
module host_model (
   // Clock
   input wire logic clk,
   // Frame: wake, standby, reset, fault clear
   output logic frame_valid,
   output logic [3:0] cmd
);
   initial begin
      frame_valid = 1'b0;
      cmd = 4'h0;
   end
   // One-cycle frame, launched just after an edge.
   task automatic send(input logic [3:0] c);
      @(posedge clk);
      frame_valid <= 1'b1;
      cmd <= c;
      @(posedge clk);
      frame_valid <= 1'b0;
      cmd <= ~c;
   endtask
endmodule

// ==== relay_driver_power_mode_reset_tb.sv ====
// Purpose: Self-checking bench for the power-mode and reset sequencer.
// Assumes: 200 MHz clock; the settle interval is waited out in full.
// Notes: Frames come from host_model; supply levels are driven here.
`timescale 1ns/10ps
module relay_driver_power_mode_reset_tb;
   logic clk, rst_b, logic_uv, battery_uv, frame_valid, bank_write, diag_write;
   logic shift_in = 1'b0;
   logic shift_out, spi_active, awake_status, settling, frame_fault_flag, uv_reset;
   logic frame_accept, diag_frame_fault, switches_enable;
   logic [3:0] cmd;
   logic [31:0] bank_wdata, bank_data;
   logic [15:0] diag_wdata, diag_data;
   logic [7:0] channel_request, channel_on;
   int failures, samples_checked;
   host_model host (.clk, .frame_valid, .cmd);
   relay_driver_power_mode_reset dut (.clk, .rst_b, .logic_uv, .battery_uv, .frame_valid,
      .wake_command_bit(cmd[3]), .standby_command_bit(cmd[2]), .reset_command_bit(cmd[1]),
      .frame_fault_clear(cmd[0]), .bank_write, .bank_wdata, .diag_write, .diag_wdata,
      .channel_request, .shift_in, .shift_out, .spi_active, .awake_status, .settling,
      .frame_fault_flag, .uv_reset, .frame_accept, .diag_frame_fault, .bank_data,
      .diag_data, .channel_on, .switches_enable);
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Toggling data keeps the pass-through under watch whenever spi_active is high.
   always @(posedge clk) shift_in <= ~shift_in;
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Wake, wait the whole settle time, then load banks and channels with a null frame.
   task automatic wake_and_load(input logic [31:0] bank_v, input logic [15:0] diag_v,
      input logic [7:0] req_v);
      host.send(4'h8);
      step(0);
      check({frame_accept, awake_status, settling}, 3'b101);
      host.send(4'h4);
      step(0);
      check({frame_accept, settling}, 2'b01);
      step(pwr_seq_pkg::WAKEUP_SETTLE_CYCLES - 10);
      check(settling, 1'b1);
      step(20);
      check({awake_status, settling}, 2'b10);
      @(posedge clk);
      {bank_write, diag_write} <= 2'b11;
      bank_wdata <= bank_v;
      diag_wdata <= diag_v;
      channel_request <= req_v;
      host.send(4'h0);
      {bank_write, diag_write} <= 2'b00;
      step(1);
      check(bank_data, bank_v);
      check(diag_data, diag_v);
      check({channel_on, switches_enable}, {req_v, 1'b1});
   endtask
   initial begin
      {rst_b, logic_uv, battery_uv, bank_write, diag_write} = 5'h00;
      bank_wdata = 32'h00000000;
      diag_wdata = 16'h0000;
      channel_request = 8'h00;
      failures = 0;
      samples_checked = 0;
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      step(10);
      check({awake_status, settling, frame_fault_flag, uv_reset, spi_active}, 5'h05);
      host.send(4'h1);
      host.send(4'hC);
      step(0);
      check({frame_accept, awake_status, settling}, 3'b100);
      wake_and_load(32'hA5C35A3C, 16'hBEEF, 8'hBC);
      host.send(4'h2);
      step(0);
      check({awake_status, frame_fault_flag, channel_on}, 10'h100);
      check({bank_data, diag_data}, 48'h0);
      host.send(4'h1);
      step(0);
      check(frame_fault_flag, 1'b0);
      host.send(4'h3);
      step(0);
      check(frame_fault_flag, 1'b1);
      wake_and_load(32'h3C5AC3A5, 16'h1234, 8'h43);
      @(posedge clk) channel_request <= 8'h81;
      step(1);
      check(channel_on, 8'h81);
      host.send(4'h4);
      step(0);
      check({awake_status, bank_data}, 33'h0);
      @(posedge clk) battery_uv <= 1'b1;
      step(8);
      check({uv_reset, spi_active, diag_frame_fault, switches_enable}, 4'hE);
      @(posedge clk) logic_uv <= 1'b1;
      step(8);
      check({uv_reset, spi_active, awake_status}, 3'b100);
      @(posedge clk) battery_uv <= 1'b0;
      step(8);
      check(uv_reset, 1'b1);
      @(posedge clk) logic_uv <= 1'b0;
      step(8);
      check({uv_reset, spi_active, frame_fault_flag}, 3'b011);
      results();
   end
   initial begin
      repeat (90000) @(posedge clk);
      failures++;
      results();
   end
endmodule
